// File: sar_adc_pkg.sv
// shared constants for the converter control block
package sar_adc_pkg;
    localparam int unsigned RESULT_BITS = 8;
    localparam int unsigned CHANNELS = 8;
    localparam int unsigned SEL_BITS = 3;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [2:0] SEL_RESET = 3'h0;
    localparam logic [7:0] LAST_SUCC_STEP = 8'h07;
    // cycles from trigger rise to done low, inside the 1..8 window
    localparam int unsigned DONE_FALL_MAX = 8;
endpackage

// File: sar_adc_mux_control.sv
// control logic of an eight-channel successive-approximation converter
`timescale 1ns/1ps
module sar_adc_mux_control #(
    parameter int unsigned RESULT_BITS = sar_adc_pkg::RESULT_BITS
) (
    input wire logic clk_in, // converter clock, 25 MHz
    input wire logic rst_in, // synchronous reset, active high
    input wire logic [2:0] chan_sel_in, // channel select, C is msb
    input wire logic addr_latch_in, // address latch strobe
    input wire logic convert_trigger_in, // start conversion pulse
    input wire logic output_enable_in, // data output enable, high
    input wire logic compare_in, // comparator: input above trial level
    output logic [7:0] channel_onehot_out, // decoded analog input select
    output logic [RESULT_BITS-1:0] trial_out, // trial code to ladder
    output logic conv_done_out, // conversion done, low while busy
    output logic [RESULT_BITS-1:0] data_out, // result data
    output logic [RESULT_BITS-1:0] data_oe_n_out // data output enable, low drives
);
    typedef enum logic [1:0] {IDLE, ARMED, CONVERT, FINISH} state_e;

    state_e state_q, state_d;
    logic latch_prev_q, trig_prev_q;
    logic [2:0] sel_q;
    logic [RESULT_BITS-1:0] sar_q, sar_d, bit_q, bit_d, result_q, result_d;
    logic done_d;
    localparam int unsigned TRIAL_W = $clog2(RESULT_BITS + 1);
    localparam int DONE_FALL_MAX = sar_adc_pkg::DONE_FALL_MAX;
    logic [TRIAL_W-1:0] trials_q;
    wire [sar_adc_pkg::CHANNELS-1:0] chan_decode;

    wire latch_rise = addr_latch_in & ~latch_prev_q;
    wire trig_rise = convert_trigger_in & ~trig_prev_q;
    wire trig_fall = ~convert_trigger_in & trig_prev_q;
    // keep trial bit if the input is above the trial level
    wire [RESULT_BITS-1:0] kept = compare_in ? (sar_q | bit_q) : sar_q;
    wire last_bit = bit_q[0];

    // one select line per analog input
    for (genvar c = 0; c < sar_adc_pkg::CHANNELS; c++)
    begin : g_chan
        assign chan_decode[c] = (sel_q == 3'(c));
    end

    always_comb
    begin
        state_d = state_q;
        sar_d = sar_q;
        bit_d = bit_q;
        result_d = result_q;
        done_d = conv_done_out;
        if (trig_rise)
        begin
            state_d = ARMED;
            sar_d = '0;
            bit_d = '0;
            done_d = 1'b0;
        end
        else
        begin
            unique case (state_q)
                IDLE: done_d = 1'b1;
                ARMED:
                    if (trig_fall)
                    begin
                        state_d = CONVERT;
                        bit_d = {1'b1, {(RESULT_BITS-1){1'b0}}};
                    end
                CONVERT:
                begin
                    sar_d = kept;
                    bit_d = bit_q >> 1;
                    if (last_bit)
                    begin
                        state_d = FINISH;
                        result_d = kept;
                    end
                end
                FINISH:
                begin
                    state_d = IDLE;
                    done_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            state_q <= IDLE;
            latch_prev_q <= 1'b0;
            trig_prev_q <= 1'b0;
            sel_q <= sar_adc_pkg::SEL_RESET;
            sar_q <= '0;
            bit_q <= '0;
            result_q <= RESULT_BITS'(sar_adc_pkg::RESULT_RESET);
            conv_done_out <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            latch_prev_q <= addr_latch_in;
            trig_prev_q <= convert_trigger_in;
            if (latch_rise)
                sel_q <= chan_sel_in;
            sar_q <= sar_d;
            bit_q <= bit_d;
            result_q <= result_d;
            conv_done_out <= done_d;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            channel_onehot_out <= 8'h01;
            trial_out <= '0;
            data_out <= RESULT_BITS'(sar_adc_pkg::RESULT_RESET);
            data_oe_n_out <= '1;
        end
        else
        begin
            channel_onehot_out <= chan_decode;
            trial_out <= sar_d | bit_d;
            data_out <= result_d;
            data_oe_n_out <= {RESULT_BITS{~output_enable_in}};
        end
    end

    // trial counter, read only by the length and msb-first checks
    always_ff @(posedge clk_in)
    begin
        if (rst_in || state_q != CONVERT)
            trials_q <= '0;
        else
            trials_q <= trials_q + TRIAL_W'(1);
    end

    // trigger, done, sequence, select latch and output enable checks
    chk_done_falls: assert property (@(posedge clk_in) disable iff (rst_in)
        trig_rise |-> ##[1:DONE_FALL_MAX] !conv_done_out)
        else $error("done did not fall after trigger");
    chk_start_on_fall: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_q == CONVERT) |-> ($past(state_q) == CONVERT || $past(trig_fall)))
        else $error("conversion began without trigger fall");
    chk_sar_cleared: assert property (@(posedge clk_in) disable iff (rst_in)
        trig_rise |=> sar_q == '0)
        else $error("register not cleared on trigger rise");
    chk_eight_trials: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_q == FINISH) |-> trials_q == TRIAL_W'(RESULT_BITS))
        else $error("conversion not eight trials long");
    chk_result_before_done: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_q == CONVERT && last_bit && !trig_rise) |=> data_out == $past(kept) && !conv_done_out
        ##1 (conv_done_out || $past(trig_rise)))
        else $error("result not loaded before done");
    chk_done_busy: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_q == CONVERT || state_q == ARMED) |-> !conv_done_out)
        else $error("done high during conversion");
    chk_latch_sel: assert property (@(posedge clk_in) disable iff (rst_in)
        latch_rise |=> sel_q == $past(chan_sel_in))
        else $error("channel select not latched");
    chk_latch_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        !latch_rise |=> $stable(sel_q))
        else $error("channel select changed without strobe");
    chk_oe_drive: assert property (@(posedge clk_in) disable iff (rst_in)
        output_enable_in |=> data_oe_n_out == '0)
        else $error("data not driven when enabled");
    chk_abort: assert property (@(posedge clk_in) disable iff (rst_in)
        trig_rise |=> state_q == ARMED)
        else $error("running conversion not abandoned");

    // done level against the sequence
    chk_idle_done: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_q == IDLE) |-> conv_done_out)
        else $error("done low while idle");
    chk_done_late: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(conv_done_out) |-> $past(state_q) == FINISH || $past(rst_in))
        else $error("done rose before last trial");
    chk_armed_wait: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_q == ARMED && !trig_fall) |=> state_q == ARMED)
        else $error("conversion began before trigger fall");

    // trial walk and result
    chk_msb_first: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_q == CONVERT && trials_q == '0) |-> bit_q == {1'b1, {(RESULT_BITS-1){1'b0}}})
        else $error("first trial not on the msb");
    chk_bit_walk: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_q == CONVERT && !last_bit && !trig_rise) |=> bit_q == ($past(bit_q) >> 1))
        else $error("trial bit did not step down");
    chk_trial_track: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_q == CONVERT) |-> trial_out == (sar_q | bit_q))
        else $error("ladder trial code out of step");
    chk_result_code: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_q == FINISH) |-> result_q == sar_q)
        else $error("result differs from decided code");
    chk_result_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        !(state_q == CONVERT && last_bit) |=> $stable(data_out))
        else $error("data changed outside a finish");

    // select decode and data enables
    chk_channel_decode: assert property (@(posedge clk_in) disable iff (rst_in)
        latch_rise |-> ##2 channel_onehot_out == (8'h01 << $past(chan_sel_in, 2)))
        else $error("wrong analog input selected");
    chk_onehot_single: assert property (@(posedge clk_in) disable iff (rst_in)
        $onehot(channel_onehot_out))
        else $error("not exactly one input selected");
    chk_oe_float: assert property (@(posedge clk_in) disable iff (rst_in)
        !output_enable_in |=> data_oe_n_out == '1)
        else $error("data driven while disabled");
endmodule

// File: analog_side_model.sv
// comparator and input mux stand-in for the analog side
`timescale 1ns/1ps
module analog_side_model (
    input wire logic [7:0] onehot_in, // selected input
    input wire logic [7:0] trial_in, // trial code
    input wire logic [63:0] levels_in, // level of each input
    output logic compare_out // input at or above trial
);
    logic [7:0] level;
    always_comb
    begin
        level = 8'h00;
        for (int i = 0; i < 8; i++)
            if (onehot_in[i])
                level = levels_in[i*8 +: 8];
    end
    assign compare_out = level >= trial_in;
endmodule

// File: sar_adc_mux_control_tb_top.sv
// random and corner conversions through the converter control
`timescale 1ns/1ps
module sar_adc_mux_control_tb_top;
    logic clk_in = 0, rst_in = 1, addr_latch_in = 0, convert_trigger_in = 0, output_enable_in = 0;
    logic [2:0] chan_sel_in = 3'h0;
    logic [63:0] levels = 64'h0;
    logic [7:0] onehot, trial, data, oe_n;
    logic compare_in, done;
    logic loop_mode = 0;
    // done fed back to the trigger while looping
    wire trig_pin = convert_trigger_in | (loop_mode & done);
    logic [31:0] seed = 32'h0001_0CDD;
    int num_errors = 0, n_compared = 0, cycles = 0, i;
    sar_adc_mux_control u_sar_adc_mux_control (.clk_in(clk_in), .rst_in(rst_in), .chan_sel_in(chan_sel_in),
        .addr_latch_in(addr_latch_in), .convert_trigger_in(trig_pin), .output_enable_in(output_enable_in),
        .compare_in(compare_in), .channel_onehot_out(onehot), .trial_out(trial), .conv_done_out(done),
        .data_out(data), .data_oe_n_out(oe_n));
    analog_side_model u_analog_side_model (.onehot_in(onehot), .trial_in(trial), .levels_in(levels),
        .compare_out(compare_in));
    initial
    begin
        forever #20 clk_in = ~clk_in;
    end
    always @(posedge clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors = num_errors + 1;
            conclude();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] level_of(input logic [2:0] ch);
        return levels[ch*8 +: 8];
    endfunction
    function automatic logic [7:0] onehot_of(input logic [2:0] ch);
        return 8'h01 << ch;
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        if (num_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // latch a channel, start, optionally restart mid-run, then read back
    task automatic convert(input logic [2:0] ch, input bit abort);
        int k;
        chan_sel_in = ch;
        addr_latch_in = 1;
        tick(1);
        addr_latch_in = 0;
        chan_sel_in = ~ch;
        convert_trigger_in = 1;
        tick(2);
        check("done", {7'h00, done}, 8'h00);
        check("onehot", onehot, onehot_of(ch));
        convert_trigger_in = 0;
        if (abort)
        begin
            tick(4);
            levels[ch*8 +: 8] = ~levels[ch*8 +: 8];
            convert_trigger_in = 1;
            tick(2);
            convert_trigger_in = 0;
        end
        for (k = 0; k < 40 && done !== 1'b1; k++)
            tick(1);
        check("done high", {7'h00, done}, 8'h01);
        check("data", data, level_of(ch));
        output_enable_in = 1;
        tick(2);
        check("oe on", oe_n, 8'h00);
        output_enable_in = 0;
        tick(2);
        check("oe off", oe_n, 8'hFF);
    endtask
    // one kick, then done restarts each conversion; a new level each round
    task automatic free_run(input logic [2:0] ch);
        int k, n;
        chan_sel_in = ch;
        addr_latch_in = 1;
        tick(1);
        addr_latch_in = 0;
        loop_mode = 1;
        convert_trigger_in = 1;
        tick(2);
        convert_trigger_in = 0;
        n = 0;
        for (k = 0; k < 60 && n < 3; k++)
        begin
            tick(1);
            if (done === 1'b1)
            begin
                check("loop data", data, level_of(ch));
                levels[ch*8 +: 8] = levels[ch*8 +: 8] + 8'h33;
                n++;
            end
        end
        loop_mode = 0;
        check("loop count", n[7:0], 8'h03);
        for (k = 0; k < 40 && done !== 1'b1; k++)
            tick(1);
    endtask
    initial
    begin
        tick(12);
        rst_in = 0;
        for (i = 0; i < 24; i++)
        begin
            seed = lfsr(seed);
            levels = {levels[55:0], seed[7:0]};
            convert(seed[10:8], seed[11]);
        end
        rst_in = 1;
        tick(2);
        check("rst done", {7'h00, done}, 8'h01);
        check("rst data", data, sar_adc_pkg::RESULT_RESET);
        check("rst oe", oe_n, 8'hFF);
        check("rst onehot", onehot, onehot_of(sar_adc_pkg::SEL_RESET));
        rst_in = 0;
        levels = 64'h0001_7F80_FF00_FE55;
        for (i = 0; i < 8; i++)
            convert(i[2:0], i[0]);
        free_run(3'h6);
        seed = lfsr(seed);
        free_run(seed[2:0]);
        conclude();
    end
endmodule
